// ---- shared/swc_regs.svh ----
// register offsets, field positions, reset values and timing counts of the sleep/wake controller
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// ============================================================
// register byte offsets
`define SWC_CTRL_OFS      8'h00
`define SWC_STAT_OFS      8'h04
`define SWC_IRQ_STAT_OFS  8'h08
`define SWC_IRQ_MASK_OFS  8'h0C
// ============================================================
// status field positions
`define SWC_PD_BIT        3
`define SWC_TO_BIT        4
`define SWC_ASLEEP_BIT    0
`define SWC_START_BIT     1
// ============================================================
// control field positions
`define SWC_CTRL_WDT_EN   0
`define SWC_CTRL_XTAL     1
`define SWC_CTRL_GIE      2
// ============================================================
// interrupt status bits: sleep entered, wake, nop sleep, watchdog time-out
`define SWC_EV_SLEEP      0
`define SWC_EV_WAKE       1
`define SWC_EV_NOP        2
`define SWC_EV_WDT        3
`define SWC_EV_W          4
// ============================================================
// reset values and timing
`define SWC_CTRL_RST      32'h0000_0001
`define SWC_OST_PERIODS   1024
`define SWC_IRQ_VECTOR    13'h0004
`endif

// ---- shared/swc_pkg.sv ----
// types of the sleep/wake controller
package swc_pkg;
    typedef enum logic [1:0] {
        SWC_RUN   = 2'b00,
        SWC_SLEEP = 2'b01,
        SWC_OST   = 2'b10
    } swc_state_t;
    typedef enum logic [1:0] {
        SWC_RESUME_INLINE = 2'b00,
        SWC_RESUME_VECTOR = 2'b01
    } swc_resume_t;
endpackage

// ---- verilog/swc_sleep_wake.sv ----
// sleep/wake sequencer with AXI4-Lite register access
// ============================================================
// Overview of operation
// (R1) sleep clears watchdog, flags, stops oscillator
// (R2) pins hold their drive state while asleep
// (R3) wake on reset, watchdog, enabled interrupt
// (R4) reset wakes fully; others continue execution
// (R5) power-down flag set at reset, cleared sleeping
// (R6) watchdog time-out clears time-out flag
// (R7) only async timer and RC converter wake
// (R8) phase clocks stopped while asleep
// (R9) next instruction prefetched during sleep
// (R10) wake needs source enable, not global enable
// (R11) after wake run next, then vector if enabled
// (R12) pending interrupt before sleep makes it nop
// (R13) interrupt during sleep: complete, wake immediately
// (R14) nop sleep leaves power-down flag set
// (R15) reset pin held high during sleep
// (R16) crystal mode waits 1024 oscillator periods
`include "swc_regs.svh"
module swc_sleep_wake #(
    parameter int WDT_PERIOD = 1800000,
    parameter int OST_CYCLES = `SWC_OST_PERIODS,
    parameter int PINS       = 13
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  sleep_exec,
    input  wire logic                  watchdog_clear_instruction,
    input  wire logic [12:0]           pc,
    input  wire logic                  ext_irq_en,
    input  wire logic                  external_irq_flag,
    input  wire logic                  upper_port_change_en,
    input  wire logic                  upper_port_change_flag,
    input  wire logic                  second_timer_en,
    input  wire logic                  second_timer_flag,
    input  wire logic                  second_timer_async,
    input  wire logic                  adc_en,
    input  wire logic                  adc_flag,
    input  wire logic                  adc_rc_clock,
    input  wire logic [PINS-1:0]       pin_out_in,
    input  wire logic [PINS-1:0]       pin_oe_in,
    output logic      [PINS-1:0]       pin_out,
    output logic      [PINS-1:0]       pin_oe,
    output logic                       osc_enable,
    output logic                       phase_clk_en,
    output logic                       core_run,
    output logic                       watchdog_reset,
    output logic                       fetch_enable,
    output logic      [12:0]           fetch_addr,
    output logic                       branch_vector,
    output logic      [12:0]           vector_addr,
    output swc_pkg::swc_resume_t       resume_kind,
    output logic                       irq,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [31:0]           s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import swc_pkg::*;

    swc_state_t           state_reg;
    logic [2:0]           ctrl_reg;
    logic                 pd_reg;
    logic                 to_reg;
    logic [`SWC_EV_W-1:0] ist_reg;
    logic [`SWC_EV_W-1:0] imask_reg;
    logic [31:0]          wdt_reg;
    logic [31:0]          ost_reg;
    logic                 aw_held_reg;
    logic                 w_held_reg;
    logic [7:0]           awaddr_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;

    // ============================================================
    // wake qualification
    logic wake_pending;
    logic wdt_timeout;
    logic sleep_go;
    logic sleep_nop;
    logic wr_fire;
    logic rd_fire;
    logic [`SWC_EV_W-1:0] ev_set;
    logic [`SWC_EV_W-1:0] ist_clr;

    // timer and converter wake only when clocked outside the stopped phase clocks
    assign wake_pending = (ext_irq_en & external_irq_flag)                        // [R10]
                        | (upper_port_change_en & upper_port_change_flag)         // [R3]
                        | (second_timer_en & second_timer_flag & second_timer_async) // [R7]
                        | (adc_en & adc_flag & adc_rc_clock);                     // [R7]
    assign wdt_timeout  = ctrl_reg[`SWC_CTRL_WDT_EN] && (wdt_reg == 32'(WDT_PERIOD - 1));
    assign sleep_go     = (state_reg == SWC_RUN) && sleep_exec && !wake_pending;
    assign sleep_nop    = (state_reg == SWC_RUN) && sleep_exec && wake_pending;   // [R12]

    // ============================================================
    // sleep state machine
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SWC_RUN;                                                 // [R4]
            ost_reg   <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                SWC_RUN: begin
                    if (sleep_go) begin
                        state_reg <= SWC_SLEEP;
                    end
                end
                SWC_SLEEP: begin
                    // a source flagged during sleep wakes on the very next edge
                    if (wake_pending || wdt_timeout) begin                       // [R3] [R13]
                        ost_reg   <= 32'h0000_0000;
                        state_reg <= ctrl_reg[`SWC_CTRL_XTAL] ? SWC_OST : SWC_RUN; // [R16]
                    end
                end
                SWC_OST: begin
                    if (ost_reg == 32'(OST_CYCLES - 1)) begin                    // [R16]
                        state_reg <= SWC_RUN;
                    end else begin
                        ost_reg <= ost_reg + 32'h0000_0001;
                    end
                end
                default: begin
                    state_reg <= SWC_RUN;
                end
            endcase
        end
    end

    // ============================================================
    // resume control
    logic wake_edge;
    assign wake_edge = (state_reg != SWC_RUN) && (state_reg == SWC_OST ? ost_reg == 32'(OST_CYCLES - 1)
                     : (!ctrl_reg[`SWC_CTRL_XTAL] && (wake_pending || wdt_timeout)));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resume_kind   <= SWC_RESUME_INLINE;
            branch_vector <= 1'b0;
        end else begin
            branch_vector <= 1'b0;
            if (wake_edge) begin
                // next instruction runs first; the core branches after it
                if (ctrl_reg[`SWC_CTRL_GIE] && wake_pending) begin               // [R11]
                    resume_kind   <= SWC_RESUME_VECTOR;
                    branch_vector <= 1'b1;
                end else begin
                    resume_kind <= SWC_RESUME_INLINE;                            // [R4]
                end
            end
        end
    end
    assign vector_addr = `SWC_IRQ_VECTOR;

    // prefetch of pc+1 is captured when sleep is accepted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_addr <= 13'h0000;
        end else if (sleep_exec && state_reg == SWC_RUN) begin
            fetch_addr <= pc + 13'h0001;                                         // [R9]
        end
    end
    assign fetch_enable = (state_reg == SWC_RUN);

    assign osc_enable   = (state_reg != SWC_SLEEP);                              // [R1]
    assign phase_clk_en = (state_reg == SWC_RUN);                                // [R8]
    assign core_run     = (state_reg == SWC_RUN);

    // ============================================================
    // pin hold: latch drive state on sleep entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else if (state_reg == SWC_RUN && !sleep_go) begin
            pin_out <= pin_out_in;
            pin_oe  <= pin_oe_in;
        end
    end                                                                          // [R2]

    // ============================================================
    // watchdog, runs on through sleep
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdt_reg        <= 32'h0000_0000;
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= wdt_timeout && state_reg == SWC_RUN;
            if (sleep_go || watchdog_clear_instruction || wdt_timeout
                || !ctrl_reg[`SWC_CTRL_WDT_EN]) begin                            // [R1]
                wdt_reg <= 32'h0000_0000;
            end else begin
                wdt_reg <= wdt_reg + 32'h0000_0001;
            end
        end
    end

    // ============================================================
    // status flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pd_reg <= 1'b1;                                                      // [R5]
            to_reg <= 1'b1;
        end else begin
            if (wdt_timeout) begin
                to_reg <= 1'b0;                                                  // [R6]
            end else if (sleep_go || watchdog_clear_instruction) begin
                to_reg <= 1'b1;                                                  // [R1]
            end
            // a nop sleep leaves the flag untouched
            if (sleep_go) begin
                pd_reg <= 1'b0;                                                  // [R5] [R14]
            end else if (watchdog_clear_instruction) begin
                pd_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // interrupt status, cleared by reading it; set wins
    assign ev_set = {wdt_timeout, sleep_nop, wake_edge, sleep_go};
    assign ist_clr = (rd_fire && s_axi_araddr == `SWC_IRQ_STAT_OFS) ? ist_reg : '0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ist_reg <= '0;
        end else begin
            ist_reg <= (ist_reg & ~ist_clr) | ev_set;
        end
    end
    assign irq = |(ist_reg & imask_reg);

    // ============================================================
    // AXI4-Lite slave
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            ctrl_reg     <= 3'(`SWC_CTRL_RST);
            imask_reg    <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                if (awaddr_reg == `SWC_CTRL_OFS) begin
                    if (wstrb_reg[0]) ctrl_reg <= wdata_reg[2:0];
                end else if (awaddr_reg == `SWC_IRQ_MASK_OFS) begin
                    if (wstrb_reg[0]) imask_reg <= wdata_reg[`SWC_EV_W-1:0];
                end else if (awaddr_reg != `SWC_STAT_OFS && awaddr_reg != `SWC_IRQ_STAT_OFS) begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (s_axi_araddr)
                `SWC_CTRL_OFS:     s_axi_rdata <= {29'h0, ctrl_reg};
                `SWC_STAT_OFS:     s_axi_rdata <= {27'h0, to_reg, pd_reg, 1'b0,
                                                   state_reg == SWC_OST, state_reg == SWC_SLEEP};
                `SWC_IRQ_STAT_OFS: s_axi_rdata <= {28'h0, ist_reg};
                `SWC_IRQ_MASK_OFS: s_axi_rdata <= {28'h0, imask_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // checks
    sleep_clears_pd_a: assert property (@(posedge clk) disable iff (!resetn)
        sleep_go |=> !pd_reg && to_reg && state_reg == SWC_SLEEP) else $error("sleep entry flags wrong"); // [R1]
    nop_keeps_pd_a: assert property (@(posedge clk) disable iff (!resetn)
        sleep_nop && !watchdog_clear_instruction |=> state_reg == SWC_RUN && pd_reg == $past(pd_reg))
        else $error("nop sleep changed state"); // [R14]
    osc_off_sleep_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == SWC_SLEEP |-> !osc_enable && !phase_clk_en) else $error("clocks on in sleep"); // [R8]
    pins_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == SWC_SLEEP && $past(state_reg) == SWC_SLEEP |-> $stable(pin_out) && $stable(pin_oe))
        else $error("pins moved in sleep"); // [R2]
    irq_wake_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == SWC_SLEEP && wake_pending |=> state_reg != SWC_SLEEP) else $error("no wake"); // [R13]
    wdt_to_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        wdt_timeout |=> !to_reg) else $error("time-out flag not cleared"); // [R6]
    gie_vector_a: assert property (@(posedge clk) disable iff (!resetn)
        wake_edge && wake_pending && ctrl_reg[`SWC_CTRL_GIE] |=> branch_vector) else $error("no vector"); // [R11]
    gated_wake_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == SWC_SLEEP && !wake_pending && !wdt_timeout |=> state_reg == SWC_SLEEP)
        else $error("spurious wake"); // [R10]
    prefetch_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        sleep_go |=> fetch_addr == $past(pc) + 13'h0001) else $error("bad prefetch"); // [R9]
    ost_wait_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == SWC_SLEEP ##1 state_reg == SWC_OST |-> state_reg == SWC_OST [*8])
        else $error("start-up delay cut short"); // [R16]
    sleep_cov_c: cover property (@(posedge clk) disable iff (!resetn) sleep_go);
    nop_cov_c: cover property (@(posedge clk) disable iff (!resetn) sleep_nop);
    wdt_wake_c: cover property (@(posedge clk) disable iff (!resetn) state_reg == SWC_SLEEP && wdt_timeout);
endmodule // swc_sleep_wake

// ---- verif/swc_partner.sv ----
// model of the reset pin and the interrupt sources around the sleep/wake controller
module swc_partner (
    input  wire logic       clk,
    output logic            resetn,
    output logic [3:0]      en,
    output logic [3:0]      flag,
    output logic            qual
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // reset pin and source levels
    initial begin
        resetn = 1'b0;
        en = 4'h0;
        flag = 4'h0;
        qual = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
    end
    // a one-cycle master clear; the pin is back high for the rest of any sleep
    task master_clear_pin;
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
    endtask
    task raise(input int s, input logic e, input logic q);
        @(posedge clk);
        en[s] <= e;
        flag[s] <= 1'b1;
        qual <= q;
    endtask
    task drop;
        @(posedge clk);
        en <= 4'h0;
        flag <= 4'h0;
    endtask
endmodule // swc_partner

// ---- verif/swc_sleep_wake_tb_top.sv ----
// self-checking bench of the sleep/wake controller against a behavioural model
`include "swc_regs.svh"
module swc_sleep_wake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    localparam int WDT_P = 50;
    localparam int OST_C = 10;
    logic        clk = 1'b0, sleep_exec = 1'b0, watchdog_clear_instruction = 1'b0, resetn, qual;
    logic [3:0]  en, flag;
    logic [12:0] pc = 13'h0, pin_out_in = 13'h0, pin_oe_in = 13'h0, pin_out, pin_oe, fetch_addr, vector_addr;
    logic        osc_enable, phase_clk_en, core_run, watchdog_reset, fetch_enable, branch_vector, irq;
    swc_resume_t resume_kind;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] rnd = 16'h0032;
    int          n_fail = 0, check_count = 0, pd_m = 1, to_m = 1, irq_m = 0, n;

    swc_sleep_wake #(.WDT_PERIOD(WDT_P), .OST_CYCLES(OST_C), .PINS(13)) dut (
        .clk, .resetn, .sleep_exec, .watchdog_clear_instruction, .pc,
        .ext_irq_en(en[0]), .external_irq_flag(flag[0]), .upper_port_change_en(en[1]),
        .upper_port_change_flag(flag[1]), .second_timer_en(en[2]), .second_timer_flag(flag[2]),
        .second_timer_async(qual), .adc_en(en[3]), .adc_flag(flag[3]), .adc_rc_clock(qual),
        .pin_out_in, .pin_oe_in, .pin_out, .pin_oe, .osc_enable, .phase_clk_en, .core_run,
        .watchdog_reset, .fetch_enable, .fetch_addr, .branch_vector, .vector_addr, .resume_kind, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    swc_partner prt (.clk, .resetn, .en, .flag, .qual);

    always #5 clk = ~clk;

    // ==========================================================
    // model helpers and bus tasks
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] stat(input logic asleep);
        return {27'h0, to_m[0], pd_m[0], 2'b00, asleep};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // awready/wready are re-sampled each edge, so either channel may be taken first
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, 2'b00);
        s_axi_bready <= 1'b0;
    endtask
    // a zero mask reads only to clear, for values the model cannot predict
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata & m, e & m);
        chk(s_axi_rresp, (a > 8'h0C) ? 2'b10 : 2'b00);
        s_axi_rready <= 1'b0;
    endtask
    task go_sleep;
        @(posedge clk);
        rnd = lfsr(rnd);
        pin_out_in <= rnd[12:0];
        pin_oe_in <= rnd[15:3];
        pc <= rnd[12:0] ^ 13'h1555;
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        pin_out_in <= ~rnd[12:0];
        pin_oe_in <= ~rnd[15:3];
        #1 chk(osc_enable, 1'b0);
        chk(phase_clk_en, 1'b0);
        chk(fetch_enable, 1'b0);
        chk(fetch_addr, 13'((rnd[12:0] ^ 13'h1555) + 13'h1));
        pd_m = 0;
        to_m = 1;
        irq_m = irq_m | 1;
        rchk(`SWC_STAT_OFS, stat(1'b1), 32'hFFFF_FFFF);
        chk(pin_out, rnd[12:0]);
        chk(pin_oe, rnd[15:3]);
    endtask
    task stop_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        wait (resetn === 1'b1);
        rchk(`SWC_CTRL_OFS, `SWC_CTRL_RST, 32'hFFFF_FFFF);
        rchk(`SWC_STAT_OFS, stat(1'b0), 32'hFFFF_FFFF);
        rchk(8'h10, 32'h0, 32'hFFFF_FFFF);
        chk(vector_addr, `SWC_IRQ_VECTOR);
        wr(`SWC_IRQ_MASK_OFS, 32'h0000_000F);
        for (int s = 0; s < 4; s++) begin
            wr(`SWC_CTRL_OFS, {29'h0, s[0], 2'b00});
            go_sleep();
            // flag without its enable, and a timer that is not counting asynchronously
            if (s % 2 == 0) begin
                prt.raise(s, s == 2, 1'b0);
                repeat (3) @(posedge clk);
                #1 chk(core_run, 1'b0);
            end
            prt.raise(s, 1'b1, 1'b1);
            @(posedge clk);
            #1 chk(core_run, 1'b1);
            chk(branch_vector, s[0]);
            chk(resume_kind, s[0]);
            irq_m = irq_m | 2;
            prt.drop();
        end
        #1 chk(irq, 1'b1);
        rchk(`SWC_IRQ_STAT_OFS, irq_m, 32'hFFFF_FFFF);
        irq_m = 0;
        @(posedge clk);
        #1 chk(irq, 1'b0);
        wr(`SWC_CTRL_OFS, 32'h0000_0002);
        go_sleep();
        prt.raise(3, 1'b1, 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (core_run !== 1'b1 && n < 100);
        chk(n - 1, OST_C);
        prt.drop();
        wr(`SWC_CTRL_OFS, 32'h0000_0001);
        go_sleep();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (core_run !== 1'b1 && n < 300);
        chk(core_run, 1'b1);
        chk(watchdog_reset, 1'b0);
        to_m = 0;
        rchk(`SWC_STAT_OFS, stat(1'b0), 32'hFFFF_FFFF);
        wr(`SWC_CTRL_OFS, 32'h0);
        rchk(`SWC_IRQ_STAT_OFS, 32'h0, 32'h0);
        @(posedge clk);
        watchdog_clear_instruction <= 1'b1;
        @(posedge clk);
        watchdog_clear_instruction <= 1'b0;
        pd_m = 1;
        to_m = 1;
        prt.raise(0, 1'b1, 1'b1);
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        #1 chk(core_run, 1'b1);
        rchk(`SWC_STAT_OFS, stat(1'b0), 32'hFFFF_FFFF);
        prt.drop();
        wr(`SWC_IRQ_MASK_OFS, 32'h0);
        #1 chk(irq, 1'b0);
        rchk(`SWC_IRQ_STAT_OFS, 32'h0000_0004, 32'hFFFF_FFFF);
        go_sleep();
        prt.master_clear_pin();
        @(posedge clk);
        #1 chk(core_run, 1'b1);
        pd_m = 1;
        to_m = 1;
        rchk(`SWC_CTRL_OFS, `SWC_CTRL_RST, 32'hFFFF_FFFF);
        rchk(`SWC_STAT_OFS, stat(1'b0), 32'hFFFF_FFFF);
        stop_test();
    end
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule // swc_sleep_wake_tb_top
